// ===== hw/stw_pkg.sv
package stw_pkg;

   // sfr addresses
   localparam logic [7:0] STW_ADDR_SEC  = 8'hf9;
   localparam logic [7:0] STW_ADDR_MS   = 8'hfa;
   localparam logic [7:0] STW_ADDR_MICROSECOND_DIVIDER = 8'hfb;
   localparam logic [7:0] STW_ADDR_MSL  = 8'hfc;
   localparam logic [7:0] STW_ADDR_MSH  = 8'hfd;
   localparam logic [7:0] STW_ADDR_HMS  = 8'hfe;
   localparam logic [7:0] STW_ADDR_WDT  = 8'hff;

   // reset values
   localparam logic [7:0] STW_RST_SEC  = 8'h7f;
   localparam logic [7:0] STW_RST_MS   = 8'h7f;
   localparam logic [7:0] STW_RST_MICROSECOND_DIVIDER = 8'h03;
   localparam logic [7:0] STW_RST_MSL  = 8'h9f;
   localparam logic [7:0] STW_RST_MSH  = 8'h0f;
   localparam logic [7:0] STW_RST_HMS  = 8'h63;
   localparam logic [7:0] STW_RST_WDT  = 8'h00;

   // field positions and widths
   localparam int STW_LOAD_NOW_BIT = 7;
   localparam int STW_WDT_EN_BIT   = 7;
   localparam int STW_WDT_DIS_BIT  = 6;
   localparam int STW_WDT_RST_BIT  = 5;
   localparam int STW_CNT_W        = 7;
   localparam int STW_MICROSECOND_DIVIDER_W       = 6;
   localparam int STW_MSDIV_W      = 16;
   localparam int STW_WDT_W        = 5;

   // one sfr access from the core, all on clk
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } stw_sfr_t;

endpackage

// ===== hw/stw_divider.sv
`timescale 1ns/1ps
module stw_divider
   import stw_pkg::*;
#(
   parameter int W = 16
)(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         run,
   input  wire logic [W-1:0] divisor,
   output logic              tick
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } stw_div_st_t;

   stw_div_st_t s;
   stw_div_st_t next_s;

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (run) begin
         // >= so a divisor lowered below the count cannot wrap
         if (s.cnt >= divisor) begin
            next_s.cnt = '0;
            next_s.tick = 1'b1;
         end else begin
            next_s.cnt = W'(s.cnt + 1'b1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_tick_single: assert property (tick && divisor != '0 |=> !tick)
      else $error("divider tick lasted more than one cycle");
   a_tick_stop: assert property (!run |=> !tick)
      else $error("divider ticked while stopped");

endmodule

// ===== hw/stw_interval.sv
`timescale 1ns/1ps
module stw_interval
   import stw_pkg::*;
#(
   parameter int         W   = 7,
   parameter logic [6:0] RST = 7'h7f
)(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         step,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output logic              expire
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         expire;
   } stw_int_st_t;

   stw_int_st_t s;
   stw_int_st_t next_s;

   always_comb begin
      next_s = s;
      next_s.expire = 1'b0;
      if (load) begin
         next_s.cnt = value;
      end else if (step) begin
         if (s.cnt == '0) begin
            // the held value is only taken here, at expiry
            next_s.cnt = value;
            next_s.expire = 1'b1;
         end else begin
            next_s.cnt = W'(s.cnt - 1'b1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s.cnt <= RST[W-1:0];
         s.expire <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign expire = s.expire;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_load_now: assert property (load |=> s.cnt == $past(value))
      else $error("immediate load not taken");
   a_defer_load: assert property (
      !load && step && s.cnt == '0 |=> expire && s.cnt == $past(value))
      else $error("deferred reload or expiry missed");

endmodule

// ===== hw/stw_top.sv
`timescale 1ns/1ps
// Behaviour
// - millisecond tick every divider high*256 plus low plus one clocks
// - hundred-ms tick every hundred_ms_divisor plus one millisecond ticks
// - microsecond tick every divisor plus one clocks; top two bits zero
// - seconds event every seconds_count plus one hundred-ms ticks
// - milliseconds event every milliseconds_count plus one ms ticks
// - write with load_now low takes effect at the next expiry
// - write with load_now high loads at once; load_now reads zero
// - reading seconds register clears seconds flag
// - reading milliseconds register clears milliseconds flag
// - writing enable bit one then zero starts watchdog counting
// - writing disable bit one then zero stops watchdog counting
// - writing restart bit one then zero clears the watchdog counter
// - watchdog expiry falls count+1 to count+2 periods after restart
// - system timer powerdown stops all ticks and interval timers
// - watchdog powerdown stops the watchdog
// - watchdog event goes high priority when priority bit set
module stw_top
   import stw_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire stw_sfr_t   sfr,
   input  wire logic       tick_timer_powerdown,
   input  wire logic       watchdog_powerdown,
   input  wire logic       watchdog_irq_priority,
   output logic [7:0]      sfr_rdata,
   output logic            microsecond_divider_tick,
   output logic            ms_divider_value_tick,
   output logic            hundred_ms_tick,
   output logic            seconds_irq,
   output logic            milliseconds_irq,
   output logic            wdt_counting,
   output logic            wdt_expire,
   output logic            wdt_irq_high,
   output logic            wdt_irq_low
);

   typedef struct packed {
      logic [7:0]           sec_val;
      logic [7:0]           ms_val;
      logic [7:0]           microsecond_divider;
      logic [7:0]           msl;
      logic [7:0]           msh;
      logic [7:0]           hms_val;
      logic [7:0]           wdt_ctl;
      logic                 sec_flag;
      logic                 ms_flag;
      logic                 wdt_en;
      logic [STW_WDT_W:0]   wdt_cnt;
      logic [7:0]           rdata;
      logic                 wdt_exp;
      logic                 irq_hi;
      logic                 irq_lo;
   } stw_top_st_t;

   localparam stw_top_st_t STW_TOP_RST = '{
      sec_val:  STW_RST_SEC,
      ms_val:   STW_RST_MS,
      microsecond_divider:     STW_RST_MICROSECOND_DIVIDER,
      msl:      STW_RST_MSL,
      msh:      STW_RST_MSH,
      hms_val:  STW_RST_HMS,
      wdt_ctl:  STW_RST_WDT,
      sec_flag: 1'b0,
      ms_flag:  1'b0,
      wdt_en:   1'b0,
      wdt_cnt:  '0,
      rdata:    8'h00,
      wdt_exp:  1'b0,
      irq_hi:   1'b0,
      irq_lo:   1'b0
   };

   stw_top_st_t s;
   stw_top_st_t next_s;

   function automatic logic wr_hit(input stw_sfr_t b, input logic [7:0] a);
      return b.wr && (b.addr == a);
   endfunction

   function automatic logic rd_hit(input stw_sfr_t b, input logic [7:0] a);
      return b.rd && (b.addr == a);
   endfunction

   // a one-then-zero sequence: stored bit high, new write drops it
   function automatic logic seq_hit(input stw_sfr_t b,
                                    input logic [7:0] held,
                                    input int bitpos);
      return wr_hit(b, STW_ADDR_WDT) && held[bitpos] && !b.wdata[bitpos];
   endfunction

   logic                 timers_run;
   logic                 sec_load;
   logic                 ms_load;
   logic                 hms_load;
   logic [STW_CNT_W-1:0] sec_value;
   logic [STW_CNT_W-1:0] ms_value;
   logic [STW_CNT_W-1:0] hms_value;
   logic                 sec_exp;
   logic                 ms_exp;
   logic                 en_seq;
   logic                 dis_seq;
   logic                 rst_seq;
   logic                 wdt_run;
   logic [STW_WDT_W:0]   wdt_term;

   assign timers_run = !tick_timer_powerdown;

   // load_now decode; immediate writes pass the new value straight through
   assign sec_load = wr_hit(sfr, STW_ADDR_SEC) && sfr.wdata[STW_LOAD_NOW_BIT];
   assign ms_load  = wr_hit(sfr, STW_ADDR_MS)  && sfr.wdata[STW_LOAD_NOW_BIT];
   assign hms_load = wr_hit(sfr, STW_ADDR_HMS) && sfr.wdata[STW_LOAD_NOW_BIT];
   assign sec_value = sec_load ? sfr.wdata[STW_CNT_W-1:0]
                               : s.sec_val[STW_CNT_W-1:0];
   assign ms_value  = ms_load ? sfr.wdata[STW_CNT_W-1:0]
                              : s.ms_val[STW_CNT_W-1:0];
   assign hms_value = hms_load ? sfr.wdata[STW_CNT_W-1:0]
                               : s.hms_val[STW_CNT_W-1:0];

   stw_divider #(
      .W       (STW_MICROSECOND_DIVIDER_W)
   ) u_microsecond_divider (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (timers_run),
      .divisor (s.microsecond_divider[STW_MICROSECOND_DIVIDER_W-1:0]),
      .tick    (microsecond_divider_tick)
   );

   stw_divider #(
      .W       (STW_MSDIV_W)
   ) u_ms_divider_value (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (timers_run),
      .divisor ({s.msh, s.msl}),
      .tick    (ms_divider_value_tick)
   );

   stw_interval #(
      .W       (STW_CNT_W),
      .RST     (STW_RST_HMS[STW_CNT_W-1:0])
   ) u_hms (
      .clk     (clk),
      .sys_rst (sys_rst),
      .step    (ms_divider_value_tick),
      .load    (hms_load),
      .value   (hms_value),
      .expire  (hundred_ms_tick)
   );

   stw_interval #(
      .W       (STW_CNT_W),
      .RST     (STW_RST_MS[STW_CNT_W-1:0])
   ) u_ms (
      .clk     (clk),
      .sys_rst (sys_rst),
      .step    (ms_divider_value_tick),
      .load    (ms_load),
      .value   (ms_value),
      .expire  (ms_exp)
   );

   stw_interval #(
      .W       (STW_CNT_W),
      .RST     (STW_RST_SEC[STW_CNT_W-1:0])
   ) u_sec (
      .clk     (clk),
      .sys_rst (sys_rst),
      .step    (hundred_ms_tick),
      .load    (sec_load),
      .value   (sec_value),
      .expire  (sec_exp)
   );

   assign en_seq  = seq_hit(sfr, s.wdt_ctl, STW_WDT_EN_BIT);
   assign dis_seq = seq_hit(sfr, s.wdt_ctl, STW_WDT_DIS_BIT);
   assign rst_seq = seq_hit(sfr, s.wdt_ctl, STW_WDT_RST_BIT);
   assign wdt_run = s.wdt_en && !watchdog_powerdown;
   // one extra tick: a restart lands anywhere in a tick period, so the
   // expiry falls count plus one to count plus two periods after it
   assign wdt_term = {1'b0, s.wdt_ctl[STW_WDT_W-1:0]} + 1'b1;

   always_comb begin
      next_s = s;
      next_s.wdt_exp = 1'b0;
      next_s.irq_hi = 1'b0;
      next_s.irq_lo = 1'b0;

      // register writes; load_now is never stored so it reads zero
      if (wr_hit(sfr, STW_ADDR_SEC)) begin
         next_s.sec_val = {1'b0, sfr.wdata[STW_CNT_W-1:0]};
      end
      if (wr_hit(sfr, STW_ADDR_MS)) begin
         next_s.ms_val = {1'b0, sfr.wdata[STW_CNT_W-1:0]};
      end
      if (wr_hit(sfr, STW_ADDR_HMS)) begin
         next_s.hms_val = {1'b0, sfr.wdata[STW_CNT_W-1:0]};
      end
      if (wr_hit(sfr, STW_ADDR_MICROSECOND_DIVIDER)) begin
         next_s.microsecond_divider = {2'b00, sfr.wdata[STW_MICROSECOND_DIVIDER_W-1:0]};
      end
      if (wr_hit(sfr, STW_ADDR_MSL)) begin
         next_s.msl = sfr.wdata;
      end
      if (wr_hit(sfr, STW_ADDR_MSH)) begin
         next_s.msh = sfr.wdata;
      end
      if (wr_hit(sfr, STW_ADDR_WDT)) begin
         next_s.wdt_ctl = sfr.wdata;
      end

      // pending flags: a new event in the read cycle survives the read
      next_s.sec_flag = (s.sec_flag && !rd_hit(sfr, STW_ADDR_SEC))
                        || sec_exp;
      next_s.ms_flag  = (s.ms_flag && !rd_hit(sfr, STW_ADDR_MS))
                        || ms_exp;

      // enable then disable order, so a write doing both leaves it off
      if (en_seq) begin
         next_s.wdt_en = 1'b1;
      end
      if (dis_seq) begin
         next_s.wdt_en = 1'b0;
      end

      if (rst_seq) begin
         next_s.wdt_cnt = '0;
      end else if (wdt_run && hundred_ms_tick) begin
         if (s.wdt_cnt >= wdt_term) begin
            next_s.wdt_cnt = '0;
            next_s.wdt_exp = 1'b1;
            next_s.irq_hi  = watchdog_irq_priority;
            next_s.irq_lo  = !watchdog_irq_priority;
         end else begin
            next_s.wdt_cnt = (STW_WDT_W+1)'(s.wdt_cnt + 1'b1);
         end
      end

      // read data is captured on the read strobe, unmapped reads give zero
      if (sfr.rd) begin
         case (sfr.addr)
            STW_ADDR_SEC:  next_s.rdata = s.sec_val;
            STW_ADDR_MS:   next_s.rdata = s.ms_val;
            STW_ADDR_MICROSECOND_DIVIDER: next_s.rdata = s.microsecond_divider;
            STW_ADDR_MSL:  next_s.rdata = s.msl;
            STW_ADDR_MSH:  next_s.rdata = s.msh;
            STW_ADDR_HMS:  next_s.rdata = s.hms_val;
            STW_ADDR_WDT:  next_s.rdata = s.wdt_ctl;
            default:       next_s.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s <= STW_TOP_RST;
      end else begin
         s <= next_s;
      end
   end

   assign sfr_rdata        = s.rdata;
   assign seconds_irq      = s.sec_flag;
   assign milliseconds_irq = s.ms_flag;
   assign wdt_counting     = s.wdt_en;
   assign wdt_expire       = s.wdt_exp;
   assign wdt_irq_high     = s.irq_hi;
   assign wdt_irq_low      = s.irq_lo;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_sec_flag_set: assert property (sec_exp |=> seconds_irq)
      else $error("seconds event not flagged");
   a_sec_read_clr: assert property (
      rd_hit(sfr, STW_ADDR_SEC) && !sec_exp |=> !seconds_irq)
      else $error("seconds read did not clear flag");
   a_ms_read_clr: assert property (
      rd_hit(sfr, STW_ADDR_MS) && !ms_exp |=> !milliseconds_irq)
      else $error("milliseconds read did not clear flag");
   a_ms_flag_hold: assert property (
      milliseconds_irq && !rd_hit(sfr, STW_ADDR_MS) |=> milliseconds_irq)
      else $error("milliseconds flag dropped without read");
   a_load_now_zero: assert property (
      sfr.rd && (sfr.addr == STW_ADDR_SEC || sfr.addr == STW_ADDR_MS
      || sfr.addr == STW_ADDR_HMS) |=> !sfr_rdata[STW_LOAD_NOW_BIT])
      else $error("load_now bit read back as one");
   a_microsecond_divider_top_zero: assert property (
      rd_hit(sfr, STW_ADDR_MICROSECOND_DIVIDER) |=> sfr_rdata[7:6] == 2'b00)
      else $error("microsecond register upper bits not zero");
   a_wdt_enable_seq: assert property (
      en_seq && !dis_seq |=> wdt_counting)
      else $error("enable sequence did not start watchdog");
   a_wdt_disable_seq: assert property (dis_seq |=> !wdt_counting)
      else $error("disable sequence did not stop watchdog");
   a_wdt_restart_seq: assert property (
      rst_seq |=> s.wdt_cnt == '0 && !wdt_expire)
      else $error("restart sequence did not clear counter");
   a_wdt_expiry: assert property (
      wdt_run && hundred_ms_tick && !rst_seq && s.wdt_cnt >= wdt_term
      |=> wdt_expire ##1 !wdt_expire)
      else $error("watchdog expiry missing or too long");
   a_wdt_powerdown: assert property (
      watchdog_powerdown && !rst_seq |=> $stable(s.wdt_cnt) && !wdt_expire)
      else $error("watchdog moved while powered down");
   a_wdt_priority: assert property (
      wdt_expire |-> (wdt_irq_high == $past(watchdog_irq_priority))
      && (wdt_irq_low != wdt_irq_high))
      else $error("watchdog priority routing wrong");
   a_timer_powerdown: assert property (
      tick_timer_powerdown[*2] |=> !microsecond_divider_tick && !ms_divider_value_tick)
      else $error("ticks ran in system timer powerdown");

   c_sec_event: cover property (sec_exp ##[1:4] rd_hit(sfr, STW_ADDR_SEC));
   c_ms_event: cover property (ms_exp);
   c_wdt_expire: cover property (wdt_expire && wdt_irq_high);
   c_deferred_write: cover property (wr_hit(sfr, STW_ADDR_MS) && !ms_load);

endmodule

// ===== tb/stw_top_tb_top.sv
`timescale 1ns/1ps
module stw_top_tb_top;
   import stw_pkg::*;

   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   stw_sfr_t   sfr = '0;
   logic       tick_timer_powerdown = 1'b1;
   logic       watchdog_powerdown = 1'b0;
   logic       watchdog_irq_priority = 1'b1;
   logic [7:0] sfr_rdata;
   logic       microsecond_divider_tick, ms_divider_value_tick, hundred_ms_tick;
   logic       seconds_irq, milliseconds_irq;
   logic       wdt_counting, wdt_expire, wdt_irq_high, wdt_irq_low;

   int         n_fail = 0;
   int         num_checks = 0;
   // event stamps: 0 microsecond_divider, 1 ms_divider_value, 2 hundred ms, 3 sec rise, 4 ms rise, 5 wdt
   int         num[6] = '{default: 0};
   int         last[6] = '{default: 0};
   int         prev[6] = '{default: 0};
   int         cyc = 0;
   logic       sec_q = 1'b0;
   logic       ms_q = 1'b0;
   logic [1:0] route = 2'b00;
   logic [5:0] ev;
   logic [7:0] rd;
   int         g, s, n0;
   logic [7:0] rst_addr[7] = '{STW_ADDR_SEC, STW_ADDR_MS, STW_ADDR_MICROSECOND_DIVIDER,
                               STW_ADDR_MSL, STW_ADDR_MSH, STW_ADDR_HMS,
                               STW_ADDR_WDT};
   logic [7:0] rst_val[7]  = '{STW_RST_SEC, STW_RST_MS, STW_RST_MICROSECOND_DIVIDER,
                               STW_RST_MSL, STW_RST_MSH, STW_RST_HMS,
                               STW_RST_WDT};

   stw_top u_dut (
      .clk                   (clk),
      .sys_rst               (sys_rst),
      .sfr                   (sfr),
      .tick_timer_powerdown  (tick_timer_powerdown),
      .watchdog_powerdown    (watchdog_powerdown),
      .watchdog_irq_priority (watchdog_irq_priority),
      .sfr_rdata             (sfr_rdata),
      .microsecond_divider_tick             (microsecond_divider_tick),
      .ms_divider_value_tick             (ms_divider_value_tick),
      .hundred_ms_tick       (hundred_ms_tick),
      .seconds_irq           (seconds_irq),
      .milliseconds_irq      (milliseconds_irq),
      .wdt_counting          (wdt_counting),
      .wdt_expire            (wdt_expire),
      .wdt_irq_high          (wdt_irq_high),
      .wdt_irq_low           (wdt_irq_low)
   );

   always #50 clk = ~clk;

   // flags are levels, so only their rising edges count as events
   assign ev = {wdt_expire, milliseconds_irq & ~ms_q, seconds_irq & ~sec_q,
                hundred_ms_tick, ms_divider_value_tick, microsecond_divider_tick};

   always @(posedge clk) begin
      cyc <= cyc + 1;
      sec_q <= seconds_irq;
      ms_q <= milliseconds_irq;
      for (int i = 0; i < 6; i++) begin
         if (ev[i]) begin
            prev[i] <= last[i];
            last[i] <= cyc;
            num[i] <= num[i] + 1;
         end
      end
      if (wdt_expire) begin
         route <= {wdt_irq_high, wdt_irq_low};
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      sfr <= '0;
   endtask

   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      sfr <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      sfr <= '0;
      @(posedge clk);
      #1;
      d = sfr_rdata;
   endtask

   // waits for n more events of one kind, bounded; returns the last gap
   task automatic wait_ev(input int i, input int n, output int gap);
      int st;
      int k;
      st = num[i];
      k = 0;
      while (num[i] < st + n && k < 20000) begin
         @(posedge clk);
         k++;
      end
      #1;
      check(16'(num[i] - st), 16'(n));
      gap = last[i] - prev[i];
   endtask

   task automatic wdt_seq(input logic [7:0] armed, input logic [7:0] done);
      sfr_write(STW_ADDR_WDT, armed);
      sfr_write(STW_ADDR_WDT, done);
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #(90_000 * 100);
      n_fail++;
      give_verdict();
   end

   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         sfr_read(rst_addr[i], rd);
         check(16'(rd), 16'(rst_val[i]));
      end
      sfr_read(8'hf8, rd);
      check(16'(rd), 16'h0000);
      $display("test reset_values done");

      // program while stopped so no divider sits above its new terminal
      sfr_write(STW_ADDR_MICROSECOND_DIVIDER, 8'h04);
      sfr_write(STW_ADDR_MSL, 8'h03);
      sfr_write(STW_ADDR_MSH, 8'h00);
      sfr_write(STW_ADDR_HMS, 8'h82);
      sfr_write(STW_ADDR_MS, 8'h84);
      sfr_write(STW_ADDR_SEC, 8'h81);
      @(posedge clk);
      tick_timer_powerdown <= 1'b0;
      wait_ev(0, 2, g);
      check(16'(g), 16'd5);
      wait_ev(1, 2, g);
      check(16'(g), 16'd4);
      wait_ev(2, 2, g);
      check(16'(g), 16'd12);
      $display("test tick_periods done");

      // flags are levels and piled up unread; clear them so a rise shows
      repeat (2) sfr_read(STW_ADDR_MS, rd);
      wait_ev(4, 1, g);
      sfr_read(STW_ADDR_MS, rd);
      check(16'(rd), 16'h0004);
      check(16'(milliseconds_irq), 16'h0000);
      sfr_write(STW_ADDR_MS, 8'h01);
      wait_ev(4, 1, g);
      check(16'(g), 16'd20);
      sfr_read(STW_ADDR_MS, rd);
      wait_ev(4, 1, g);
      check(16'(g), 16'd8);
      sfr_read(STW_ADDR_MS, rd);
      sfr_write(STW_ADDR_MS, 8'hc0);
      wait_ev(4, 1, g);
      check(16'(g >= 200), 16'h0001);
      $display("test ms_interval done");

      repeat (2) sfr_read(STW_ADDR_SEC, rd);
      wait_ev(3, 1, g);
      sfr_read(STW_ADDR_SEC, rd);
      check(16'(rd), 16'h0001);
      check(16'(seconds_irq), 16'h0000);
      wait_ev(3, 1, g);
      check(16'(g), 16'd24);
      $display("test seconds_interval done");

      wdt_seq(8'h82, 8'h02);
      #1;
      check(16'(wdt_counting), 16'h0001);
      wait_ev(5, 2, g);
      check(16'(g), 16'd48);
      check(16'(route), 16'h0002);
      @(posedge clk);
      watchdog_irq_priority <= 1'b0;
      wait_ev(5, 1, g);
      check(16'(route), 16'h0001);
      n0 = num[5];
      repeat (6) begin
         wdt_seq(8'h22, 8'h02);
         repeat (14) @(posedge clk);
      end
      check(16'(num[5]), 16'(n0));
      wdt_seq(8'h22, 8'h02);
      s = cyc;
      wait_ev(5, 1, g);
      // restart to expiry is 36 to 48 cycles; the stamps lag it by three
      check(16'((cyc - s) >= 39 && (cyc - s) <= 51), 16'h0001);
      wdt_seq(8'h42, 8'h02);
      #1;
      check(16'(wdt_counting), 16'h0000);
      n0 = num[5];
      repeat (100) @(posedge clk);
      check(16'(num[5]), 16'(n0));
      wdt_seq(8'h82, 8'h02);
      watchdog_powerdown <= 1'b1;
      repeat (100) @(posedge clk);
      check(16'(num[5]), 16'(n0));
      watchdog_powerdown <= 1'b0;
      $display("test watchdog done");

      tick_timer_powerdown <= 1'b1;
      @(posedge clk);
      #1;
      n0 = num[0] + num[1];
      repeat (50) @(posedge clk);
      #1;
      check(16'(num[0] + num[1]), 16'(n0));
      @(posedge clk);
      tick_timer_powerdown <= 1'b0;
      $display("test powerdown done");

      sfr_write(STW_ADDR_MICROSECOND_DIVIDER, 8'hff);
      sfr_read(STW_ADDR_MICROSECOND_DIVIDER, rd);
      check(16'(rd), 16'h003f);
      sfr_write(8'hf8, 8'h55);
      sfr_read(8'hf8, rd);
      check(16'(rd), 16'h0000);
      sfr_write(STW_ADDR_MSH, 8'h01);
      sfr_write(STW_ADDR_MSL, 8'h02);
      wait_ev(1, 2, g);
      check(16'(g), 16'd259);
      $display("test registers done");
      give_verdict();
   end
endmodule
